/* hw/cct_timer.sv */
// Capture/compare timer channel with classic Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module cct_timer
  import cct_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        tap_div1_i,
  input  wire logic        tap_div4_i,
  input  wire logic        tap_div16_i,
  input  wire logic        external_count_input_i,
  input  wire logic        capture_input_i,
  input  wire logic        capture_trigger_i,
  output logic             timer_output_pin_o,
  output logic             timer_interrupt_o,
  output logic             capture_a_interrupt_o,
  output logic             capture_b_interrupt_o
);
  import cct_pkg::*;

  localparam int NPIN = 3;

  // Register state
  logic             ack_reg;
  logic [31:0]      rdata_reg;
  logic             module_enable_reg;
  logic             run_control_reg;
  logic             prescaler_run_reg;
  logic             double_buffer_enable_reg;
  cct_src_t         clock_select_reg;
  logic             clear_on_match_enable_reg;
  cct_capmode_t     capture_mode_reg;
  logic [3:0]       toggle_en_reg;
  logic [CCT_W-1:0] compare_reg_a;
  logic [CCT_W-1:0] compare_reg_b;
  logic [CCT_W-1:0] buffer_a_reg;
  logic [CCT_W-1:0] buffer_b_reg;
  logic [7:0]       low_hold_a_reg;
  logic [7:0]       low_hold_b_reg;
  logic [CCT_W-1:0] capture_reg_a;
  logic [CCT_W-1:0] capture_reg_b;
  logic [CCT_W-1:0] up_counter;
  logic [CCT_W-1:0] up_counter_next;
  logic             output_flipflop;
  logic             output_flipflop_next;
  logic             tint_reg;
  logic             capa_int_reg;
  logic             capb_int_reg;

  // Synchronised pin events
  logic [NPIN-1:0]  pin_raw;
  logic [NPIN-1:0]  pin_rise;
  logic [NPIN-1:0]  pin_fall;

  assign pin_raw = {capture_trigger_i, capture_input_i,
                    external_count_input_i};

  // Detectors reset to the idle low level, so a pin low at reset gives no edge after it
  // input synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      cct_edge u_edge (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  (pin_raw[gi]),
        .rise_o (pin_rise[gi]),
        .fall_o (pin_fall[gi])
      );
    end
  endgenerate

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Bus decode; a write lands on the edge where ack is high
  wire        bus_req  = cyc_i & stb_i;
  wire        wr_go    = bus_req & we_i & ack_reg;
  wire        wr_en    = wr_go & hit(adr_i, OFS_ENABLE) & sel_i[0];
  wire        wr_run   = wr_go & hit(adr_i, OFS_RUN) & sel_i[0];
  wire        wr_chctl = wr_go & hit(adr_i, OFS_CHCTL) & sel_i[0];
  wire        wr_mode  = wr_go & hit(adr_i, OFS_MODE) & sel_i[0];
  wire        wr_ffctl = wr_go & hit(adr_i, OFS_FFCTL) & sel_i[0];
  wire        wr_cmpa  = wr_go & hit(adr_i, OFS_CMPA);
  wire        wr_cmpb  = wr_go & hit(adr_i, OFS_CMPB);

  // A high byte alone commits whatever low byte was last held
  // low byte is held until the high byte completes the word
  wire        lo_only  = sel_i[0] & ~sel_i[1];
  wire        hi_go    = sel_i[1];
  wire [15:0] word_a   = sel_i[0] ? dat_i[15:0] : {dat_i[15:8], low_hold_a_reg};
  wire [15:0] word_b   = sel_i[0] ? dat_i[15:0] : {dat_i[15:8], low_hold_b_reg};
  wire        ld_a     = wr_cmpa & hi_go;
  wire        ld_b     = wr_cmpb & hi_go;

  // writing 0 to the software capture bit latches capture A
  wire        sw_cap   = wr_mode & ~dat_i[SWCAP_BIT];

  // External events arrive two clocks late through the synchroniser
  // count source selection
  wire        src_tick = (clock_select_reg == CCT_SRC_EXT)   ? pin_rise[0] :
                         (clock_select_reg == CCT_SRC_DIV1)  ? tap_div1_i :
                         (clock_select_reg == CCT_SRC_DIV4)  ? tap_div4_i :
                                                               tap_div16_i;
  // Clearing run control zeroes the count; clearing prescaler run or module enable only holds it
  // counting needs module, run and prescaler run all set
  wire        running  = module_enable_reg & run_control_reg
                         & prescaler_run_reg;
  wire        tick     = running & src_tick;

  // comparators, one pulse per counter step taken from the value
  wire        match_a  = tick & (up_counter == compare_reg_a);
  wire        match_b  = tick & (up_counter == compare_reg_b);
  wire        clr_hit  = match_b & clear_on_match_enable_reg;
  // A clear on the wrapping tick is a match, not an overflow
  // overflow when a full counter steps
  wire        overflow = tick & (up_counter == CNT_MAX) & ~clr_hit;
  // buffer transfer on compare B match
  wire        xfer     = match_b & double_buffer_enable_reg;

  wire        ev_rise  = (capture_mode_reg != CCT_CAP_OFF)
                         & (capture_mode_reg != CCT_CAP_TRIGGER)
                         & pin_rise[1];
  wire        ev_fall  = (capture_mode_reg == CCT_CAP_BOTH) & pin_fall[1];
  wire        tr_rise  = (capture_mode_reg == CCT_CAP_TRIGGER) & pin_rise[2];
  wire        tr_fall  = (capture_mode_reg == CCT_CAP_TRIGGER) & pin_fall[2];
  wire        cap_a    = ev_rise | tr_rise | sw_cap;
  wire        cap_b    = ev_fall | tr_fall;

  always_comb begin
    up_counter_next = up_counter;
    if (!run_control_reg) begin
      up_counter_next = '0;
    end else if (clr_hit) begin
      up_counter_next = '0;
    end else if (tick) begin
      up_counter_next = up_counter + 16'h0001;
    end
  end

  // toggle sources, each behind its enable
  wire        tog_ev   = (match_a & toggle_en_reg[0])
                         | (match_b & toggle_en_reg[1])
                         | (cap_a & toggle_en_reg[2])
                         | (cap_b & toggle_en_reg[3]);
  wire [1:0]  ff_cmd   = dat_i[FFCMD_LSB+1:FFCMD_LSB];

  // a set, clear or toggle command wins over a same-cycle hardware toggle; keep lets it through
  always_comb begin
    output_flipflop_next = output_flipflop;
    if (wr_ffctl) begin
      unique case (cct_ffcmd_t'(ff_cmd))
        CCT_FF_TOGGLE: output_flipflop_next = ~output_flipflop;
        CCT_FF_SET:    output_flipflop_next = 1'b1;
        CCT_FF_CLEAR:  output_flipflop_next = 1'b0;
        CCT_FF_KEEP:   output_flipflop_next = output_flipflop ^ tog_ev;
      endcase
    end else if (tog_ev) begin
      output_flipflop_next = ~output_flipflop;
    end
  end

  // Counter and flip-flop state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_counter      <= '0;
      // Documented as undefined; zero keeps the pin quiet until set up
      output_flipflop <= 1'b0;
    end else begin
      up_counter      <= up_counter_next;
      output_flipflop <= output_flipflop_next;
    end
  end

  // Interrupt pulses are registered so that each lasts one clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tint_reg     <= 1'b0;
      capa_int_reg <= 1'b0;
      capb_int_reg <= 1'b0;
    end else begin
      tint_reg     <= overflow | match_a | match_b;
      capa_int_reg <= cap_a;
      capb_int_reg <= cap_b;
    end
  end

  // captures hold until the next latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_reg_a <= '0;
      capture_reg_b <= '0;
    end else begin
      if (cap_a) capture_reg_a <= up_counter;
      if (cap_b) capture_reg_b <= up_counter;
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      module_enable_reg         <= 1'b0;
      run_control_reg           <= 1'b0;
      prescaler_run_reg         <= 1'b0;
      double_buffer_enable_reg  <= 1'b0;
      clock_select_reg          <= cct_src_t'(CLKSEL_RST);
      clear_on_match_enable_reg <= 1'b0;
      capture_mode_reg          <= cct_capmode_t'(CAPMODE_RST);
      toggle_en_reg             <= TOG_RST;
    end else begin
      if (wr_en) module_enable_reg <= dat_i[ENABLE_BIT];
      if (wr_run) begin
        run_control_reg   <= dat_i[RUN_BIT];
        prescaler_run_reg <= dat_i[PRUN_BIT];
      end
      if (wr_chctl) double_buffer_enable_reg <= dat_i[DBUF_BIT];
      if (wr_mode) begin
        clock_select_reg          <= cct_src_t'(dat_i[CLKSEL_LSB+1:CLKSEL_LSB]);
        clear_on_match_enable_reg <= dat_i[CLEAR_BIT];
        capture_mode_reg <= cct_capmode_t'(dat_i[CAPMODE_LSB+1:CAPMODE_LSB]);
      end
      if (wr_ffctl) toggle_en_reg <= dat_i[TOG_CB_BIT:TOG_MA_BIT];
    end
  end

  // Compare registers and their buffers
  // Direct writes need the double buffer off, so they never meet a buffer transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // contents are not meant to be relied on
      compare_reg_a  <= CMP_RST;
      compare_reg_b  <= CMP_RST;
      buffer_a_reg   <= CMP_RST;
      buffer_b_reg   <= CMP_RST;
      low_hold_a_reg <= 8'h00;
      low_hold_b_reg <= 8'h00;
    end else begin
      if (wr_cmpa & lo_only) low_hold_a_reg <= dat_i[7:0];
      if (wr_cmpb & lo_only) low_hold_b_reg <= dat_i[7:0];
      // shared address for register and buffer
      if (ld_a) buffer_a_reg <= word_a;
      if (ld_b) buffer_b_reg <= word_b;
      // buffered load at compare B match
      if (xfer) begin
        compare_reg_a <= buffer_a_reg;
        compare_reg_b <= buffer_b_reg;
      end
      // unbuffered write reaches the compare directly
      if (ld_a & ~double_buffer_enable_reg) compare_reg_a <= word_a;
      if (ld_b & ~double_buffer_enable_reg) compare_reg_b <= word_b;
    end
  end

  // Read multiplexer; unmapped offsets read as zero
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    unique case (adr_i)
      OFS_ENABLE: rmux[ENABLE_BIT] = module_enable_reg;
      OFS_RUN: begin
        rmux[RUN_BIT]  = run_control_reg;
        rmux[PRUN_BIT] = prescaler_run_reg;
      end
      OFS_CHCTL: rmux[DBUF_BIT] = double_buffer_enable_reg;
      OFS_MODE: begin
        rmux[CLKSEL_LSB+1:CLKSEL_LSB]   = clock_select_reg;
        rmux[CLEAR_BIT]                 = clear_on_match_enable_reg;
        rmux[CAPMODE_LSB+1:CAPMODE_LSB] = capture_mode_reg;
        rmux[SWCAP_BIT]                 = 1'b1;
      end
      OFS_FFCTL: begin
        rmux[TOG_CB_BIT:TOG_MA_BIT]   = toggle_en_reg;
        rmux[FFCMD_LSB+1:FFCMD_LSB]   = CCT_FF_KEEP;
      end
      // Reading shows the double buffer when it is enabled
      OFS_CMPA: rmux[15:0] = double_buffer_enable_reg ? buffer_a_reg
                                                      : compare_reg_a;
      OFS_CMPB: rmux[15:0] = double_buffer_enable_reg ? buffer_b_reg
                                                      : compare_reg_b;
      OFS_CAPA: rmux[15:0] = capture_reg_a;
      OFS_CAPB: rmux[15:0] = capture_reg_b;
      OFS_LIVE: rmux[15:0] = up_counter;
      default:  rmux = 32'h0000_0000;
    endcase
  end

  // One wait state: ack in the cycle after the request appears
  // Registered read data costs the wait state but keeps dat_o clean
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg   <= bus_req & ~ack_reg;
      rdata_reg <= rmux;
    end
  end

  assign ack_o                 = ack_reg;
  assign dat_o                 = rdata_reg;
  assign timer_output_pin_o    = output_flipflop;
  assign timer_interrupt_o     = tint_reg;
  assign capture_a_interrupt_o = capa_int_reg;
  assign capture_b_interrupt_o = capb_int_reg;
endmodule
`default_nettype wire

/* hw/cct_pkg.sv */
// Shared constants for the capture/compare timer channel
package cct_pkg;
  localparam int          CCT_W        = 16;
  localparam logic [7:0]  OFS_ENABLE   = 8'h00;
  localparam logic [7:0]  OFS_RUN      = 8'h04;
  localparam logic [7:0]  OFS_CHCTL    = 8'h08;
  localparam logic [7:0]  OFS_MODE     = 8'h0c;
  localparam logic [7:0]  OFS_FFCTL    = 8'h10;
  localparam logic [7:0]  OFS_CMPA     = 8'h14;
  localparam logic [7:0]  OFS_CMPB     = 8'h18;
  localparam logic [7:0]  OFS_CAPA     = 8'h1c;
  localparam logic [7:0]  OFS_CAPB     = 8'h20;
  localparam logic [7:0]  OFS_LIVE     = 8'h24;
  // Field positions
  localparam int          ENABLE_BIT   = 7;
  localparam int          RUN_BIT      = 0;
  localparam int          PRUN_BIT     = 2;
  localparam int          DBUF_BIT     = 7;
  localparam int          CLKSEL_LSB   = 0;
  localparam int          CLEAR_BIT    = 2;
  localparam int          CAPMODE_LSB  = 3;
  localparam int          SWCAP_BIT    = 5;
  localparam int          FFCMD_LSB    = 0;
  localparam int          TOG_MA_BIT   = 2;
  localparam int          TOG_MB_BIT   = 3;
  localparam int          TOG_CA_BIT   = 4;
  localparam int          TOG_CB_BIT   = 5;
  // Reset values and the counter maximum
  localparam logic [15:0] CMP_RST      = 16'h0000;
  localparam logic [15:0] CNT_MAX      = 16'hffff;
  localparam logic [1:0]  CLKSEL_RST   = 2'h0;
  localparam logic [1:0]  CAPMODE_RST  = 2'h0;
  localparam logic [3:0]  TOG_RST      = 4'h0;
  // Clock sources
  typedef enum logic [1:0] {
    CCT_SRC_EXT  = 2'h0,
    CCT_SRC_DIV1 = 2'h1,
    CCT_SRC_DIV4 = 2'h2,
    CCT_SRC_DIV16 = 2'h3
  } cct_src_t;
  // Capture triggers
  typedef enum logic [1:0] {
    CCT_CAP_OFF     = 2'h0,
    CCT_CAP_RISE    = 2'h1,
    CCT_CAP_BOTH    = 2'h2,
    CCT_CAP_TRIGGER = 2'h3
  } cct_capmode_t;
  // Flip-flop write commands
  typedef enum logic [1:0] {
    CCT_FF_TOGGLE = 2'h0,
    CCT_FF_SET    = 2'h1,
    CCT_FF_CLEAR  = 2'h2,
    CCT_FF_KEEP   = 2'h3
  } cct_ffcmd_t;
endpackage

/* hw/cct_edge.sv */
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module cct_edge (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Only sync_reg looks at the first stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise_o = sync_reg & ~last_reg;
  assign fall_o = ~sync_reg & last_reg;
endmodule
`default_nettype wire

/* tb/cct_timer_asserts.sv */
// Port assertions for the timer channel
`timescale 1ns/1ps
`default_nettype none
module cct_timer_asserts
  import cct_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  input  wire logic        timer_output_pin_o,
  input  wire logic        timer_interrupt_o,
  input  wire logic        capture_a_interrupt_o,
  input  wire logic        capture_b_interrupt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Only a write that the slave acknowledges carries a command
  sequence s_ff(logic [1:0] c);
    ack_o && we_i && sel_i[0] && adr_i == OFS_FFCTL && dat_i[1:0] == c;
  endsequence
  property p_ack_wait;
    s_req |=> ack_o;
  endproperty
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  property p_ti_one;
    timer_interrupt_o |=> !timer_interrupt_o;
  endproperty
  property p_ca_one;
    capture_a_interrupt_o |=> !capture_a_interrupt_o;
  endproperty
  property p_cb_one;
    capture_b_interrupt_o |=> !capture_b_interrupt_o;
  endproperty
  property p_ff_set;
    s_ff(2'h1) |=> timer_output_pin_o;
  endproperty
  property p_ff_clr;
    s_ff(2'h2) |=> !timer_output_pin_o;
  endproperty
  property p_ff_tog;
    s_ff(2'h0) |=> timer_output_pin_o != $past(timer_output_pin_o);
  endproperty
  a_ack_wait: assert property (p_ack_wait)
    else $error("ack not one cycle after request");
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  a_ti_one: assert property (p_ti_one)
    else $error("timer interrupt longer than one cycle");
  a_ca_one: assert property (p_ca_one)
    else $error("capture a interrupt longer than one cycle");
  a_cb_one: assert property (p_cb_one)
    else $error("capture b interrupt longer than one cycle");
  a_ff_set: assert property (p_ff_set)
    else $error("set command did not raise output");
  a_ff_clr: assert property (p_ff_clr)
    else $error("clear command did not lower output");
  a_ff_tog: assert property (p_ff_tog)
    else $error("toggle command did not invert output");
endmodule
`default_nettype wire

/* tb/cct_pins_model.sv */
// Model of the event and capture pins beside the timer channel
`timescale 1ns/1ps
`default_nettype none
module cct_pins_model (
  input  wire logic clk_i,
  output logic      ext_o,
  output logic      cap_o,
  output logic      trg_o
);
  initial begin
    ext_o = 1'b0;
    cap_o = 1'b0;
    trg_o = 1'b0;
  end
  // rising count edges
  // Three clocks high and four low, above the two-clock minimum
  task automatic count(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task automatic cap_pulse;
    @(posedge clk_i);
    cap_o <= 1'b1;
    trg_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    cap_o <= 1'b0;
    trg_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* tb/cct_timer_test.sv */
// Self-checking bench for the timer channel
`timescale 1ns/1ps
`default_nettype none
module cct_timer_test;
  import cct_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        cyc, stb, we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, dout;
  logic [5:0]  pc = 6'h00;
  logic        t1, t4, t16;
  logic        ack, pin, ti, ia, ib;
  wire logic   ext, cap, trg;
  int          n_fail = 0, cmp_count = 0, n_ti = 0, n_ia = 0, n_ib = 0;

  cct_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dout),
    .ack_o(ack), .tap_div1_i(t1), .tap_div4_i(t4), .tap_div16_i(t16),
    .external_count_input_i(ext), .capture_input_i(cap),
    .capture_trigger_i(trg), .timer_output_pin_o(pin),
    .timer_interrupt_o(ti), .capture_a_interrupt_o(ia),
    .capture_b_interrupt_o(ib));
  cct_pins_model pins (.clk_i(clk_i), .ext_o(ext), .cap_o(cap),
    .trg_o(trg));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Prescaler ticks and interrupt pulse counters
  always @(posedge clk_i) begin
    pc <= pc + 6'h01;
    // The divide-by-one tap misses one tick in 64
    t1 <= (pc != 6'h3f);
    t4 <= (pc[2:0] == 3'h0);
    t16 <= (pc[4:0] == 5'h00);
    if (ti === 1'b1) n_ti++;
    if (ia === 1'b1) n_ia++;
    if (ib === 1'b1) n_ib++;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(posedge clk_i);
    repeat (20) if (ack !== 1'b1) @(posedge clk_i);
    if (ack !== 1'b1) begin
      n_fail++;
      $display("MISMATCH ack expected 1 seen %b", ack);
    end
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, rdat);
  endtask
  // Pin is looked at one edge after the write that launched it
  task automatic chk_pin(input string nm, input logic e);
    @(posedge clk_i);
    chk(nm, {31'h0, e}, {31'h0, pin});
  endtask
  // Cycles until the pin leaves level v, bounded at 200
  task automatic level_len(input logic v, output int n);
    n = 0;
    while (pin === v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic t_regs;
    rd_chk("mode", OFS_MODE, 32'h20);
    rd_chk("ffctl", OFS_FFCTL, 32'h3);
    rd_chk("chctl", OFS_CHCTL, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd_chk("hole", 8'h40, 32'h0);
    rd_chk("live", OFS_LIVE, 32'h0);
  endtask
  task automatic t_event;
    wr(OFS_ENABLE, 32'h80);
    wr(OFS_MODE, 32'h20);
    wr(OFS_RUN, 32'h5);
    pins.count(5);
    rd_chk("events", OFS_LIVE, 32'h5);
    wr(OFS_RUN, 32'h4);
    rd_chk("stopped", OFS_LIVE, 32'h0);
    wr(OFS_RUN, 32'h5);
  endtask
  task automatic t_cmp;
    wb(1'b1, OFS_CMPA, 32'h34, 4'h1);
    wb(1'b1, OFS_CMPA, 32'h1200, 4'h2);
    rd_chk("cmpa bytes", OFS_CMPA, 32'h1234);
    wr(OFS_CMPA, 32'h1);
    wr(OFS_CMPB, 32'h3);
    rd_chk("cmpb", OFS_CMPB, 32'h3);
  endtask
  task automatic t_match;
    int n0;
    n0 = n_ti;
    wr(OFS_MODE, 32'h24);
    wr(OFS_FFCTL, 32'he);
    pins.count(2);
    chk("pin match a", 32'h1, {31'h0, pin});
    pins.count(2);
    chk("pin match b", 32'h0, {31'h0, pin});
    rd_chk("cleared", OFS_LIVE, 32'h0);
    chk("match ints", n0 + 2, n_ti);
    wr(OFS_FFCTL, 32'h1);
    chk_pin("ff set", 1'b1);
    wr(OFS_FFCTL, 32'h2);
    chk_pin("ff clear", 1'b0);
    wr(OFS_FFCTL, 32'h0);
    chk_pin("ff toggle", 1'b1);
  endtask
  task automatic t_dbuf;
    wr(OFS_CHCTL, 32'h80);
    wr(OFS_CMPB, 32'h5);
    pins.count(4);
    rd_chk("old period", OFS_LIVE, 32'h0);
    pins.count(5);
    rd_chk("new period", OFS_LIVE, 32'h5);
    pins.count(1);
    rd_chk("new wrap", OFS_LIVE, 32'h0);
    wr(OFS_CHCTL, 32'h0);
  endtask
  task automatic t_capture;
    int a0, b0;
    pins.count(2);
    wr(OFS_MODE, 32'h04);
    rd_chk("sw capture", OFS_CAPA, 32'h2);
    pins.count(1);
    for (int m = 0; m < 4; m++) begin
      a0 = n_ia;
      b0 = n_ib;
      wr(OFS_MODE, 32'h24 | (32'(m) << 3));
      pins.cap_pulse();
      chk("capture a int", a0 + (m != 0), n_ia);
      chk("capture b int", b0 + (m >= 2), n_ib);
    end
    rd_chk("capa", OFS_CAPA, 32'h3);
    rd_chk("capb", OFS_CAPB, 32'h3);
  endtask
  // Divide-by-4 ticks every 8 clocks: high 4 ticks, low 3 ticks
  task automatic t_square;
    int n;
    wr(OFS_ENABLE, 32'h80);
    wr(OFS_RUN, 32'h0);
    wr(OFS_CMPA, 32'h2);
    wr(OFS_CMPB, 32'h6);
    wr(OFS_CHCTL, 32'h80);
    wr(OFS_FFCTL, 32'he);
    wr(OFS_MODE, 32'h26);
    chk_pin("sq start", 1'b0);
    wr(OFS_RUN, 32'h5);
    level_len(1'b0, n);
    level_len(1'b1, n);
    chk("sq high", 32'h20, n);
    level_len(1'b0, n);
    chk("sq low", 32'h18, n);
    wr(OFS_RUN, 32'h4);
    wr(OFS_CHCTL, 32'h0);
    wr(OFS_FFCTL, 32'h3);
    wr(OFS_MODE, 32'h20);
  endtask
  task automatic t_taps;
    int n0;
    wr(OFS_RUN, 32'h5);
    // A window of 64 edges holds exactly two divide-by-16 ticks
    wr(OFS_MODE, 32'h23);
    repeat (61) @(posedge clk_i);
    wr(OFS_MODE, 32'h20);
    rd_chk("div16 ticks", OFS_LIVE, 32'h2);
    n0 = n_ti;
    wr(OFS_MODE, 32'h21);
    repeat (66700) @(posedge clk_i);
    wr(OFS_MODE, 32'h20);
    // Matches at 2 and 6 on both sides of the wrap, plus the overflow
    chk("wrap ints", n0 + 5, n_ti);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    rst_i <= 1'b1;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= 8'h00;
    sel <= 4'h0;
    dat <= 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_event();
    t_cmp();
    t_match();
    t_dbuf();
    t_capture();
    t_square();
    t_taps();
    report_and_stop();
  end
  // The wrap test alone needs some 67000 cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end
endmodule
bind cct_timer cct_timer_asserts chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .timer_output_pin_o(timer_output_pin_o),
  .timer_interrupt_o(timer_interrupt_o),
  .capture_a_interrupt_o(capture_a_interrupt_o),
  .capture_b_interrupt_o(capture_b_interrupt_o));
`default_nettype wire
